// ==== src/acr_pkg.sv ====
// Purpose: Shared constants and types of the accelerometer control registers.
// Assumes: Byte-wide register access from the serial interface engine.
// Notes: All offsets, fields and defaults live here.
package acr_pkg;
   // Register addresses.
   localparam logic [6:0] ADDR_RATE = 7'h20;
   localparam logic [6:0] ADDR_IF = 7'h21;
   localparam logic [6:0] ADDR_IRQ = 7'h22;
   localparam logic [6:0] ADDR_OUT_FIRST = 7'h28;
   localparam logic [6:0] ADDR_OUT_LAST = 7'h2d;
   // Reset values.
   localparam logic [7:0] RST_RATE = 8'h00;
   localparam logic [7:0] RST_IF = 8'h04;
   localparam logic [7:0] RST_IRQ = 8'h00;
   // Rate and power register fields.
   localparam int RATE_HI = 7;
   localparam int RATE_LO = 4;
   localparam int MODE_HI = 3;
   localparam int MODE_LO = 2;
   localparam int LPS_HI = 1;
   localparam int LPS_LO = 0;
   // Interface and reset register bits.
   localparam int IF_TRIM = 7;
   localparam int IF_SOFT = 6;
   localparam int IF_PULLUP_OFF = 4;
   localparam int IF_HOLD = 3;
   localparam int IF_AUTO_INC = 2;
   localparam int IF_I2C_OFF = 1;
   localparam int IF_SPI3 = 0;
   // Interrupt pad and self-test register bits.
   localparam int IRQ_ST_HI = 7;
   localparam int IRQ_ST_LO = 6;
   localparam int IRQ_OD = 5;
   localparam int IRQ_LATCH = 4;
   localparam int IRQ_POL = 3;
   localparam int IRQ_RSVD = 2;
   localparam int IRQ_SRC = 1;
   localparam int IRQ_START = 0;
   // Field codes.
   localparam logic [3:0] RATE_OFF = 4'h0;
   localparam logic [3:0] RATE_1 = 4'h1;
   localparam logic [3:0] RATE_LP_CAP = 4'h6;
   localparam logic [3:0] RATE_MAX = 4'h9;
   localparam logic [1:0] MODE_LP = 2'h0;
   localparam logic [1:0] MODE_HP = 2'h1;
   localparam logic [1:0] MODE_OD = 2'h2;
   localparam logic [1:0] LPS_1 = 2'h0;
   localparam logic [1:0] ST_POS = 2'h1;
   localparam logic [1:0] ST_NEG = 2'h2;

   typedef enum logic [1:0] {
      OD_IDLE = 2'b01,
      OD_WAIT = 2'b10
   } acr_od_state_t;

   // Decoded configuration driven to the sensor core.
   typedef struct packed {
      logic power_down;
      logic [3:0] rate_code;
      logic rate_1p6;
      logic high_perf;
      logic on_demand;
      logic res_14bit;
      logic [1:0] lp_submode;
      logic cs_pullup_on;
      logic pair_hold;
      logic auto_inc;
      logic i2c_on;
      logic spi_three_wire;
      logic selftest_pos;
      logic selftest_neg;
      logic irq_open_drain;
      logic irq_latched;
      logic irq_active_low;
   } acr_cfg_t;

   // One byte access from the serial interface engine.
   typedef struct packed {
      logic load;
      logic [6:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } acr_acc_t;
endpackage : acr_pkg

// ==== src/acr_regs.sv ====
// Purpose: Control registers for rate, mode, interface, pads and on-demand conversion.
// Assumes: Access strobes and sensor core events are one-cycle pulses on i_clk.
// Notes: The second interrupt pin arrives from outside and is synchronised.
`timescale 1ns/10ps
`default_nettype none
module acr_regs (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Register access.
   input wire acr_pkg::acr_acc_t i_acc,
   output logic [7:0] o_rdata,
   output logic [6:0] o_addr,
   // Sensor core events and the second interrupt pin.
   input wire logic i_trim_done,
   input wire logic i_data_ready,
   input wire logic i_sample_taken,
   input wire logic i_irq_pin_two,
   // Sensor core controls.
   output acr_pkg::acr_cfg_t o_cfg,
   output logic o_trim_reload,
   output logic o_conv_start,
   output logic o_out_update_ok
);
   logic [7:0] rate_ff;
   logic [7:0] nxt_rate;
   logic [7:0] if_ff;
   logic [7:0] nxt_if;
   logic [7:0] irq_ff;
   logic [7:0] nxt_irq;
   logic [6:0] addr_ff;
   logic [6:0] nxt_addr;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   acr_pkg::acr_cfg_t cfg_ff;
   acr_pkg::acr_cfg_t nxt_cfg;
   acr_pkg::acr_od_state_t od_ff;
   acr_pkg::acr_od_state_t nxt_od;
   logic start_ff;
   logic nxt_start;
   logic lo_rd_ff;
   logic nxt_lo_rd;
   logic hi_rd_ff;
   logic nxt_hi_rd;
   logic upd_ok_ff;
   logic nxt_upd_ok;
   logic pin_s1_ff;
   logic pin_s2_ff;
   logic pin_s3_ff;
   logic [6:0] cur_addr;
   logic wr_rate;
   logic wr_if;
   logic wr_irq;
   logic trig;

   // A load strobe supplies the address of the first byte of an access.
   assign cur_addr = i_acc.load ? i_acc.addr : addr_ff;
   assign wr_rate = i_acc.wr && (cur_addr == acr_pkg::ADDR_RATE);
   assign wr_if = i_acc.wr && (cur_addr == acr_pkg::ADDR_IF);
   assign wr_irq = i_acc.wr && (cur_addr == acr_pkg::ADDR_IRQ);

   always_comb begin
      nxt_rate = rate_ff;
      nxt_if = if_ff;
      nxt_irq = irq_ff;
      if (wr_rate) begin
         nxt_rate = i_acc.wdata;
      end
      if (wr_if) begin
         nxt_if = i_acc.wdata;
      end
      if (wr_irq) begin
         nxt_irq = i_acc.wdata;
         nxt_irq[acr_pkg::IRQ_RSVD] = 1'b0;
      end
      // A write of one wins over the completion clear in the same cycle.
      if (i_trim_done && !(wr_if && i_acc.wdata[acr_pkg::IF_TRIM])) begin
         nxt_if[acr_pkg::IF_TRIM] = 1'b0;
      end
      nxt_irq[acr_pkg::IRQ_START] = nxt_start;
      // Soft reset takes a cycle; it clears itself with the other defaults.
      if (if_ff[acr_pkg::IF_SOFT]) begin
         nxt_rate = acr_pkg::RST_RATE;
         nxt_if = acr_pkg::RST_IF;
         nxt_irq = acr_pkg::RST_IRQ;
      end
   end

   always_comb begin
      nxt_addr = cur_addr;
      if ((i_acc.wr || i_acc.rd) && if_ff[acr_pkg::IF_AUTO_INC]) begin
         nxt_addr = 7'(cur_addr + 7'h01);
      end
      nxt_rdata = rdata_ff;
      if (i_acc.rd) begin
         case (cur_addr)
            acr_pkg::ADDR_RATE: nxt_rdata = rate_ff;
            acr_pkg::ADDR_IF: nxt_rdata = if_ff;
            acr_pkg::ADDR_IRQ: nxt_rdata = irq_ff;
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   // Pin two is a level from outside; only the second stage reads the first, stages two and three detect the edge.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pin_s1_ff <= 1'b0;
         pin_s2_ff <= 1'b0;
         pin_s3_ff <= 1'b0;
      end else begin
         pin_s1_ff <= i_irq_pin_two;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
      end
   end

   // The trigger is ignored unless on-demand mode is selected.
   always_comb begin
      if (irq_ff[acr_pkg::IRQ_SRC]) begin
         trig = irq_ff[acr_pkg::IRQ_START];
      end else begin
         trig = pin_s2_ff && !pin_s3_ff;
      end
      trig = trig && (rate_ff[acr_pkg::MODE_HI:acr_pkg::MODE_LO] == acr_pkg::MODE_OD);
      nxt_od = od_ff;
      nxt_start = irq_ff[acr_pkg::IRQ_START];
      if (wr_irq && i_acc.wdata[acr_pkg::IRQ_START]) begin
         nxt_start = 1'b1;
      end
      case (od_ff)
         acr_pkg::OD_IDLE: begin
            if (trig) begin
               nxt_od = acr_pkg::OD_WAIT;
            end
         end
         acr_pkg::OD_WAIT: begin
            if (i_data_ready) begin
               nxt_od = acr_pkg::OD_IDLE;
               if (!(wr_irq && i_acc.wdata[acr_pkg::IRQ_START])) begin
                  nxt_start = 1'b0;
               end
            end
         end
         default: nxt_od = acr_pkg::OD_IDLE;
      endcase
   end

   // Reads of an output pair are tracked so a half-read pair does not change while the hold bit is set.
   always_comb begin
      nxt_lo_rd = lo_rd_ff;
      nxt_hi_rd = hi_rd_ff;
      if (i_sample_taken) begin
         nxt_lo_rd = 1'b0;
         nxt_hi_rd = 1'b0;
      end
      if (i_acc.rd && (cur_addr >= acr_pkg::ADDR_OUT_FIRST) && (cur_addr <= acr_pkg::ADDR_OUT_LAST)) begin
         if (cur_addr[0]) begin
            nxt_hi_rd = 1'b1;
         end else begin
            nxt_lo_rd = 1'b1;
         end
      end
      nxt_upd_ok = !nxt_if[acr_pkg::IF_HOLD] || (nxt_lo_rd && nxt_hi_rd);
   end

   always_comb begin
      nxt_cfg.power_down = (nxt_rate[acr_pkg::RATE_HI:acr_pkg::RATE_LO] == acr_pkg::RATE_OFF);
      nxt_cfg.high_perf = (nxt_rate[acr_pkg::MODE_HI:acr_pkg::MODE_LO] == acr_pkg::MODE_HP);
      nxt_cfg.on_demand = (nxt_rate[acr_pkg::MODE_HI:acr_pkg::MODE_LO] == acr_pkg::MODE_OD);
      nxt_cfg.lp_submode = nxt_rate[acr_pkg::LPS_HI:acr_pkg::LPS_LO];
      nxt_cfg.res_14bit = nxt_cfg.high_perf || (nxt_cfg.lp_submode != acr_pkg::LPS_1);
      nxt_cfg.rate_code = nxt_rate[acr_pkg::RATE_HI:acr_pkg::RATE_LO];
      if (nxt_cfg.rate_code > acr_pkg::RATE_MAX) begin
         nxt_cfg.rate_code = acr_pkg::RATE_MAX;
      end
      // Low-power operation cannot exceed 200 Hz.
      if (!nxt_cfg.high_perf && (nxt_cfg.rate_code > acr_pkg::RATE_LP_CAP)) begin
         nxt_cfg.rate_code = acr_pkg::RATE_LP_CAP;
      end
      nxt_cfg.rate_1p6 = !nxt_cfg.high_perf && (nxt_cfg.rate_code == acr_pkg::RATE_1);
      nxt_cfg.cs_pullup_on = !nxt_if[acr_pkg::IF_PULLUP_OFF];
      nxt_cfg.pair_hold = nxt_if[acr_pkg::IF_HOLD];
      nxt_cfg.auto_inc = nxt_if[acr_pkg::IF_AUTO_INC];
      nxt_cfg.i2c_on = !nxt_if[acr_pkg::IF_I2C_OFF];
      nxt_cfg.spi_three_wire = nxt_if[acr_pkg::IF_SPI3];
      nxt_cfg.selftest_pos = (nxt_irq[acr_pkg::IRQ_ST_HI:acr_pkg::IRQ_ST_LO] == acr_pkg::ST_POS);
      nxt_cfg.selftest_neg = (nxt_irq[acr_pkg::IRQ_ST_HI:acr_pkg::IRQ_ST_LO] == acr_pkg::ST_NEG);
      nxt_cfg.irq_open_drain = nxt_irq[acr_pkg::IRQ_OD];
      nxt_cfg.irq_latched = nxt_irq[acr_pkg::IRQ_LATCH];
      nxt_cfg.irq_active_low = nxt_irq[acr_pkg::IRQ_POL];
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rate_ff <= acr_pkg::RST_RATE;
         if_ff <= acr_pkg::RST_IF;
         irq_ff <= acr_pkg::RST_IRQ;
         addr_ff <= 7'h00;
         rdata_ff <= 8'h00;
         od_ff <= acr_pkg::OD_IDLE;
         start_ff <= 1'b0;
         lo_rd_ff <= 1'b0;
         hi_rd_ff <= 1'b0;
         upd_ok_ff <= 1'b1;
         cfg_ff <= '0;
      end else begin
         rate_ff <= nxt_rate;
         if_ff <= nxt_if;
         irq_ff <= nxt_irq;
         addr_ff <= nxt_addr;
         rdata_ff <= nxt_rdata;
         od_ff <= nxt_od;
         start_ff <= (od_ff == acr_pkg::OD_IDLE) && trig;
         lo_rd_ff <= nxt_lo_rd;
         hi_rd_ff <= nxt_hi_rd;
         upd_ok_ff <= nxt_upd_ok;
         cfg_ff <= nxt_cfg;
      end
   end

   assign o_rdata = rdata_ff;
   assign o_addr = addr_ff;
   assign o_cfg = cfg_ff;
   assign o_trim_reload = if_ff[acr_pkg::IF_TRIM];
   assign o_conv_start = start_ff;
   assign o_out_update_ok = upd_ok_ff;
endmodule : acr_regs
`default_nettype wire

// ==== tb/acr_regs_chk.sv ====
// Purpose: Port checks of the control registers.
// Assumes: Bench keeps bit 6 of 0x21 low in random traffic.
// Notes: A written byte shows on o_cfg from the edge that takes it, together with the register.
`timescale 1ns/10ps
`default_nettype none
module acr_regs_chk (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Watched ports.
   input wire acr_pkg::acr_acc_t i_acc,
   input wire logic [6:0] o_addr,
   input wire logic i_trim_done,
   input wire logic i_data_ready,
   input wire logic i_sample_taken,
   input wire acr_pkg::acr_cfg_t o_cfg,
   input wire logic o_trim_reload,
   input wire logic o_conv_start,
   input wire logic o_out_update_ok
);
   logic [6:0] ea;
   logic [7:0] d;
   logic w20;
   logic w21;
   logic w22;
   logic busy_ff;
   logic nxt_busy;
   assign ea = i_acc.load ? i_acc.addr : o_addr;
   assign d = i_acc.wdata;
   assign w20 = i_acc.wr && ea == acr_pkg::ADDR_RATE;
   assign w21 = i_acc.wr && ea == acr_pkg::ADDR_IF;
   assign w22 = i_acc.wr && ea == acr_pkg::ADDR_IRQ;
   // A conversion in flight hides new triggers, so those are not checked.
   always_comb nxt_busy = o_conv_start | (busy_ff & ~i_data_ready);
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) busy_ff <= 1'b0;
      else busy_ff <= nxt_busy;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   AST_RATE: assert property (w20 |-> ##1 o_cfg.high_perf == ($past(d[3:2]) == 2'h1)
      && o_cfg.on_demand == ($past(d[3:2]) == 2'h2) && o_cfg.power_down == ($past(d[7:4]) == 4'h0))
      else $error("Rate register decode wrong.");
   AST_RES: assert property (w20 |-> ##1 o_cfg.res_14bit ==
      ($past(d[3:2]) == 2'h1 || $past(d[1:0]) != 2'h0)) else $error("Resolution wrong.");
   AST_IF: assert property (w21 && !d[6] |-> ##1 o_cfg.cs_pullup_on != $past(d[4])
      && o_cfg.i2c_on != $past(d[1]) && o_cfg.spi_three_wire == $past(d[0])
      && o_cfg.pair_hold == $past(d[3])) else $error("Interface decode wrong.");
   AST_IRQ: assert property (w22 |-> ##1 o_cfg.irq_open_drain == $past(d[5])
      && o_cfg.irq_latched == $past(d[4]) && o_cfg.irq_active_low == $past(d[3])
      && o_cfg.selftest_pos == ($past(d[7:6]) == 2'h1)
      && o_cfg.selftest_neg == ($past(d[7:6]) == 2'h2)) else $error("Pad decode wrong.");
   AST_SOFT: assert property (w21 && d[6] |-> ##2 o_cfg.power_down && o_cfg.auto_inc
      && !o_cfg.irq_latched && o_cfg.i2c_on) else $error("Soft reset missed.");
   AST_TRIM_SET: assert property (w21 && d[7] |=> o_trim_reload) else $error("Trim not set.");
   AST_TRIM_CLR: assert property (i_trim_done && !(w21 && d[7]) |=> !o_trim_reload)
      else $error("Trim not cleared.");
   AST_START: assert property (w22 && d[1] && d[0] && o_cfg.on_demand && !busy_ff && !o_conv_start
      |-> ##2 o_conv_start) else $error("Start missed.");
   AST_PULSE: assert property (o_conv_start |=> !o_conv_start) else $error("Start too long.");
   AST_ADDR: assert property (i_acc.rd || i_acc.wr |=> o_addr == $past(ea) + {6'h0, $past(o_cfg.auto_inc)})
      else $error("Address step wrong.");
   AST_HOLD: assert property (o_cfg.pair_hold && i_sample_taken && !i_acc.rd |=> !o_out_update_ok)
      else $error("Hold not applied.");
endmodule : acr_regs_chk
bind acr_regs acr_regs_chk i_acr_regs_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_acc(i_acc), .o_addr(o_addr),
   .i_trim_done(i_trim_done), .i_data_ready(i_data_ready), .i_sample_taken(i_sample_taken), .o_cfg(o_cfg),
   .o_trim_reload(o_trim_reload), .o_conv_start(o_conv_start), .o_out_update_ok(o_out_update_ok));
`default_nettype wire

// ==== tb/acr_core_model.sv ====
// Purpose: Sensor core stand-in answering trim and conversion requests.
// Assumes: Requests arrive on the register clock.
// Notes: A large i_delay makes the core slow, so the host must poll.
`timescale 1ns/10ps
`default_nettype none
module acr_core_model (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Requests and pacing.
   input wire logic i_trim_reload,
   input wire logic i_conv_start,
   input wire logic [3:0] i_delay,
   // Completion pulses.
   output logic o_trim_done,
   output logic o_data_ready
);
   logic [3:0] tcnt_ff;
   logic [3:0] ccnt_ff;
   logic cbusy_ff;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         {tcnt_ff, ccnt_ff, cbusy_ff, o_trim_done, o_data_ready} <= '0;
      end else begin
         // One completion for each trim request.
         o_trim_done <= i_trim_reload && !o_trim_done && tcnt_ff == i_delay;
         tcnt_ff <= (i_trim_reload && tcnt_ff != i_delay) ? tcnt_ff + 4'h1 : 4'h0;
         // Data become ready some cycles after each start.
         cbusy_ff <= i_conv_start || (cbusy_ff && ccnt_ff != i_delay);
         ccnt_ff <= cbusy_ff ? ccnt_ff + 4'h1 : 4'h0;
         o_data_ready <= cbusy_ff && ccnt_ff == i_delay;
      end
   end
endmodule : acr_core_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the control registers.
// Assumes: The host polls self-clearing bits before writing on.
// Notes: Random writes keep bits 7:5 of 0x21 and bit 0 of 0x22 low.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   acr_pkg::acr_acc_t acc = '0;
   logic pin = 1'b0;
   logic smp = 1'b0;
   logic [3:0] dly = 4'h1;
   logic [7:0] rdata;
   logic [6:0] addr;
   acr_pkg::acr_cfg_t cfg;
   logic trim, tdone, dready, start, upd;
   logic [7:0] rv;
   logic [7:0] r [3];
   int error_cnt = 0;
   int samples_checked = 0;
   int seed = 93058;
   always #12.5 i_clk = ~i_clk;
   acr_regs i_acr_regs (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_acc(acc), .o_rdata(rdata), .o_addr(addr),
      .i_trim_done(tdone), .i_data_ready(dready), .i_sample_taken(smp), .i_irq_pin_two(pin),
      .o_cfg(cfg), .o_trim_reload(trim), .o_conv_start(start), .o_out_update_ok(upd));
   acr_core_model i_acr_core_model (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_trim_reload(trim),
      .i_conv_start(start), .i_delay(dly), .o_trim_done(tdone), .o_data_ready(dready));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Each access is one cycle long and followed by an idle cycle.
   task automatic op(input logic ld, input logic [6:0] a, input logic w, input logic [7:0] wd);
      @(posedge i_clk);
      acc <= '{ld, a, w, ~w, wd};
      @(posedge i_clk);
      acc <= '0;
      #1 rv = rdata;
   endtask : op
   task automatic poll(input logic [6:0] a, input logic [7:0] m);
      for (int n = 0; n < 40; n++) begin
         op(1'b1, a, 1'b0, 8'h00);
         if ((rv & m) === 8'h00) return;
      end
      error_cnt++;
      disable run.main;
   endtask : poll
   task automatic wait_start(output int n);
      for (n = 0; n < 20; n++) begin
         @(posedge i_clk);
         #1;
         if (start === 1'b1) return;
      end
      error_cnt++;
      disable run.main;
   endtask : wait_start
   function automatic acr_pkg::acr_cfg_t ecfg(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      logic hp;
      logic [3:0] rc;
      hp = a[3:2] == 2'h1;
      rc = (a[7:4] > 4'h9) ? 4'h9 : a[7:4];
      if (!hp && rc > 4'h6) rc = 4'h6;
      return '{a[7:4] == 4'h0, rc, a[7:4] == 4'h1 && !hp, hp, a[3:2] == 2'h2, hp || a[1:0] != 2'h0, a[1:0],
         !b[4], b[3], b[2], !b[1], b[0], c[7:6] == 2'h1, c[7:6] == 2'h2, c[5], c[4], c[3]};
   endfunction : ecfg
   task automatic rd_all;
      acr_pkg::acr_cfg_t s;
      for (int i = 0; i < 3; i++) begin
         op(1'b1, 7'h20 + 7'(i), 1'b0, 8'h00);
         chk("register", 32'(rv), 32'(r[i]));
      end
      s = cfg;
      chk("cfg", 32'(s), 32'(ecfg(r[0], r[1], r[2])));
   endtask : rd_all
   initial begin : run
      begin : main
         int k;
         int lat;
         logic [7:0] v;
         repeat (5) @(posedge i_clk);
         i_rst_b <= 1'b1;
         r = '{8'h00, 8'h04, 8'h00};
         rd_all();
         chk("upd", 32'(upd), 32'h1);
         for (int i = 0; i < 60; i++) begin
            k = $unsigned($random(seed)) % 4;
            v = 8'($random(seed));
            if (k == 3) begin
               op(1'b1, 7'h30, 1'b1, v);
               op(1'b1, 7'h30, 1'b0, 8'h00);
               chk("unmapped", 32'(rv), 32'h0);
            end else begin
               if (k == 0 && v[3:2] == 2'h3) v[3] = 1'b0;
               if (k == 1) v = v & 8'h1f;
               if (k == 2 && v[7:6] == 2'h3) v[6] = 1'b0;
               if (k == 2) v[0] = 1'b0;
               op(1'b1, 7'h20 + 7'(k), 1'b1, v);
               r[k] = (k == 2) ? v & 8'hfb : v;
               rd_all();
            end
         end
         op(1'b1, 7'h21, 1'b1, 8'h04);
         op(1'b1, 7'h20, 1'b0, 8'h00);
         op(1'b0, 7'h00, 1'b0, 8'h00);
         chk("inc", {rv, 1'b0, addr}, {8'h04, 8'h22});
         op(1'b1, 7'h21, 1'b1, 8'h08);
         op(1'b1, 7'h21, 1'b0, 8'h00);
         op(1'b0, 7'h00, 1'b0, 8'h00);
         chk("noinc", {rv, 1'b0, addr}, {8'h08, 8'h21});
         @(posedge i_clk);
         smp <= 1'b1;
         @(posedge i_clk);
         smp <= 1'b0;
         op(1'b1, 7'h28, 1'b0, 8'h00);
         chk("upd", 32'(upd), 32'h0);
         op(1'b1, 7'h29, 1'b0, 8'h00);
         @(posedge i_clk);
         #1 chk("upd", 32'(upd), 32'h1);
         dly <= 4'h8;
         op(1'b1, 7'h21, 1'b1, 8'h84);
         op(1'b1, 7'h21, 1'b0, 8'h00);
         chk("trim", 32'(rv), 32'h84);
         poll(7'h21, 8'h80);
         op(1'b1, 7'h22, 1'b1, 8'h38);
         op(1'b1, 7'h21, 1'b1, 8'h4a);
         poll(7'h21, 8'h40);
         r = '{8'h00, 8'h04, 8'h00};
         rd_all();
         dly <= 4'h3;
         op(1'b1, 7'h20, 1'b1, 8'h28);
         op(1'b1, 7'h22, 1'b1, 8'h03);
         wait_start(lat);
         chk("start latency", 32'(lat), 32'h0);
         poll(7'h22, 8'h01);
         op(1'b1, 7'h22, 1'b1, 8'h00);
         @(posedge i_clk);
         pin <= 1'b1;
         wait_start(lat);
         chk("pin start", 32'(start), 32'h1);
         chk("pin latency", 32'(lat), 32'h2);
      end
      final_report();
   end
   task automatic final_report;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report
endmodule : tb_top
`default_nettype wire
